// File: qtd_pkg.sv
// Constants, register map and shared helpers for the quench threshold detector
// Behaviour
// R1: Four channels, 24-bit, 100 kHz, eleven ranges
// R2: Samples averaged down to 1 kHz
// R3: Moving average on decimated stream, configurable window
// R4: Window settable from 1 ms to 1 s
// R5: Reported reading is moving-average output
// R6: Threshold crossing sets channel status bit
// R7: Relay output is OR of status bits
// R8: Status latches until host clears it
// R9: Absolute thresholds compared as magnitudes
// R10: Each channel has own absolute threshold
// R11: Six pair thresholds on difference magnitude
// R12: Pair difference sign kept for readout
// R13: Both heater outputs switched together
// R14: Lowest range step equals 2.5 nV
// R15: Differences from same-update filter outputs
// R16: Relay drops only after all flags cleared
package qtd_pkg;
   // Timing
   localparam int CLK_HZ     = 20_000_000;
   localparam int SAMPLE_KHZ = 100;
   localparam int UPDATE_MS  = 1;
   localparam int TICK_CYC   = CLK_HZ / 1000 * UPDATE_MS;
   localparam int WIN_MIN_MS = 1;
   localparam int WIN_MAX_MS = 1000;
   localparam logic [9:0] WIN_MIN = 10'(WIN_MIN_MS / UPDATE_MS);
   localparam logic [9:0] WIN_MAX = 10'(WIN_MAX_MS / UPDATE_MS);
   localparam int DIV_STEPS  = 36;
   // Sizes
   localparam int N_CH   = 4;
   localparam int N_PAIR = 6;
   localparam logic [3:0] N_RANGE     = 4'hb;
   localparam logic [7:0] DEC_CNT_MAX = 8'hff;
   // Lowest range step in pV (2.5 nV)
   localparam logic [31:0] LSB_PV_LOW = 32'h0000_09c4;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_WINDOW    = 8'h04;
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_CLEAR     = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
   localparam logic [7:0] ADDR_DSIGN     = 8'h14;
   localparam logic [7:0] ADDR_LSB       = 8'h18;
   localparam logic [7:0] ADDR_RANGE     = 8'h20;
   localparam logic [7:0] ADDR_ABS_THR   = 8'h30;
   localparam logic [7:0] ADDR_READING   = 8'h40;
   localparam logic [7:0] ADDR_DIFF_THR  = 8'h50;
   localparam logic [7:0] ADDR_DIFF_VAL  = 8'h70;
   // Field positions
   localparam int CTRL_HEATER_BIT = 0;
   localparam int STAT_DIFF_LSB   = 4;
   // Reset values; thresholds start out of reach
   localparam logic [9:0]  WINDOW_RST   = 10'h001;
   localparam logic [3:0]  RANGE_RST    = 4'h0;
   localparam logic [23:0] ABS_THR_RST  = 24'hff_ffff;
   localparam logic [24:0] DIFF_THR_RST = 25'h1ff_ffff;

   // Channel pairs in order 1-2,1-3,1-4,2-3,2-4,3-4
   function automatic logic [1:0] pair_a(input int k);
      return (k < 3) ? 2'h0 : (k < 5) ? 2'h1 : 2'h2;
   endfunction

   function automatic logic [1:0] pair_b(input int k);
      unique case (k)
         0: return 2'h1;
         1, 3: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction
endpackage

// File: qtd_chan_filter.sv
// One channel: block-average decimator and sliding window filter
`timescale 1ns/10ps
module qtd_chan_filter (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               tick,
   input  wire logic               sample_valid,
   input  wire logic signed [23:0] sample_data,
   input  wire logic [9:0]         window,
   output logic signed [23:0]      reading,
   output logic                    reading_valid
);
   import qtd_pkg::*;

   typedef enum logic [1:0] {QTD_IDLE, QTD_DIV_DEC, QTD_PUSH, QTD_DIV_WIN} qtd_fsm_t;

   typedef struct packed {
      qtd_fsm_t           fsm;
      logic signed [31:0] acc;
      logic [7:0]         cnt;
      logic [35:0]        dq;
      logic [9:0]         rem;
      logic [9:0]         div;
      logic               neg;
      logic [5:0]         step;
      logic signed [23:0] dec;
      logic signed [35:0] wsum;
      logic [9:0]         fill;
      logic [9:0]         win_q;
      logic [9:0]         wp;
      logic signed [23:0] rd;
      logic               vld;
   } qtd_filt_t;

   qtd_filt_t         s;
   qtd_filt_t         n;
   logic signed [23:0] mem [0:1023];

   // Next state
   always_comb begin
      logic [10:0]        t;
      logic               qb;
      logic signed [35:0] q;
      t = '0;
      qb = 1'b0;
      q = '0;
      n = s;
      n.vld = 1'b0;
      // Block average of the samples seen in each update period
      if (tick) begin // R2
         n.acc = sample_valid ? 32'(sample_data) : '0;
         n.cnt = {7'h00, sample_valid};
      end else if (sample_valid && s.cnt != DEC_CNT_MAX) begin // R1
         n.acc = s.acc + 32'(sample_data);
         n.cnt = s.cnt + 8'h01;
      end
      unique case (s.fsm)
         QTD_IDLE: begin
            if (tick) begin
               n.neg = s.acc[31];
               n.dq = 36'(s.acc[31] ? -s.acc : s.acc);
               n.div = (s.cnt == 8'h00) ? 10'h001 : {2'h0, s.cnt};
               n.rem = '0;
               n.step = '0;
               n.fsm = QTD_DIV_DEC;
            end
            // New window length restarts the filter cleanly
            if (window != s.win_q) begin // R4
               n.win_q = window;
               n.fill = '0;
               n.wsum = '0;
            end
         end
         QTD_DIV_DEC, QTD_DIV_WIN: begin
            // Shared restoring divider, one quotient bit a cycle
            t = {s.rem, s.dq[35]};
            qb = (t >= {1'b0, s.div});
            n.dq = {s.dq[34:0], qb};
            n.rem = qb ? 10'(t - {1'b0, s.div}) : t[9:0];
            n.step = s.step + 6'h01;
            if (s.step == 6'(DIV_STEPS - 1)) begin
               q = s.neg ? -$signed(n.dq) : $signed(n.dq);
               if (s.fsm == QTD_DIV_DEC) begin
                  n.dec = 24'(q);
                  n.fsm = QTD_PUSH;
               end else begin
                  n.rd = 24'(q); // R5
                  n.vld = 1'b1;
                  n.fsm = QTD_IDLE;
               end
            end
         end
         QTD_PUSH: begin
            // Running sum: add newest, drop the one leaving the window
            if (s.fill == s.win_q) begin // R3
               n.wsum = s.wsum + 36'(s.dec) - 36'(mem[10'(s.wp - s.win_q)]);
            end else begin
               n.wsum = s.wsum + 36'(s.dec);
               n.fill = s.fill + 10'h001;
            end
            n.wp = s.wp + 10'h001;
            n.neg = n.wsum[35];
            n.dq = n.wsum[35] ? 36'(-n.wsum) : 36'(n.wsum);
            n.div = n.fill;
            n.rem = '0;
            n.step = '0;
            n.fsm = QTD_DIV_WIN;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.fsm <= QTD_IDLE;
         s.win_q <= WINDOW_RST;
      end else begin
         s <= n;
      end
   end

   // Decimated history; no reset needed, fill count guards stale words
   always_ff @(posedge pclk) begin
      if (s.fsm == QTD_PUSH) begin
         mem[s.wp] <= s.dec;
      end
   end

   assign reading = s.rd;
   assign reading_valid = s.vld;
endmodule

// File: qtd_top.sv
// Quench threshold detector top: APB registers, comparators, relay
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
module qtd_top #(
   parameter int TICK_CYC = qtd_pkg::TICK_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  sample_valid,
   input  wire logic [3:0][23:0] sample_data,
   output logic [3:0][3:0]  range_sel,
   output logic             quench_relay,
   output logic             switch_heater_output_a,
   output logic             switch_heater_output_b,
   output logic             irq
);
   import qtd_pkg::*;

   typedef struct packed {
      logic [9:0]       window;
      logic             heater;
      logic [9:0]       status;
      logic [9:0]       irq_en;
      logic [5:0]       dsign;
      logic [3:0][3:0]  range_sel;
      logic [3:0][23:0] abs_thr;
      logic [5:0][24:0] diff_thr;
      logic [14:0]      tick_cnt;
      logic             tick;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             quench;
      logic             irq;
      logic             heat_a;
      logic             heat_b;
   } qtd_regs_t;

   qtd_regs_t        r;
   qtd_regs_t        n;
   logic [3:0][23:0] rd;
   logic [3:0]       rd_valid;
   logic [5:0][24:0] diff;

   // Address falls inside a block of word registers
   function automatic logic in_blk(
      input logic [7:0] a,
      input logic [7:0] base,
      input int         cnt
   );
      return (a >= base) && (a < 8'(base + 4 * cnt)) && (a[1:0] == 2'h0);
   endfunction

   // Index of a word within a block
   function automatic int blk_idx(
      input logic [7:0] a,
      input logic [7:0] base
   );
      return int'(8'(a - base) >> 2);
   endfunction

   // Magnitude above threshold, either polarity
   function automatic logic over_mag(
      input logic signed [24:0] v,
      input logic [24:0]        th
   );
      logic [24:0] mag;
      mag = v[24] ? 25'(-v) : 25'(v);
      return mag > th;
   endfunction

   // One filter per channel, all stepped by the same update tick
   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         qtd_chan_filter u_filt (
            .pclk          (pclk),
            .presetn       (presetn),
            .tick          (r.tick),
            .sample_valid  (sample_valid[g]),
            .sample_data   (sample_data[g]),
            .window        (r.window),
            .reading       (rd[g]),
            .reading_valid (rd_valid[g])
         );
      end
   endgenerate

   // Pair differences from readings of the same update
   always_comb begin
      for (int k = 0; k < N_PAIR; k++) begin
         diff[k] = 25'($signed(rd[pair_a(k)])) - 25'($signed(rd[pair_b(k)])); // R15
      end
   end

   // Next state
   always_comb begin
      logic [31:0] rdata;
      logic        hit;
      logic        wr;
      logic        setup;
      logic [9:0]  set;
      logic [9:0]  clr;
      int          i;
      rdata = '0;
      hit = 1'b0;
      wr = 1'b0;
      setup = 1'b0;
      set = '0;
      clr = '0;
      i = 0;
      n = r;

      // Update period timebase
      n.tick = 1'b0;
      if (r.tick_cnt == 15'(TICK_CYC - 1)) begin
         n.tick_cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = r.tick_cnt + 15'h0001;
      end

      // Read decode, also flags unmapped addresses
      if (paddr == ADDR_CTRL) begin
         hit = 1'b1;
         rdata[CTRL_HEATER_BIT] = r.heater;
      end else if (paddr == ADDR_WINDOW) begin
         hit = 1'b1;
         rdata = 32'(r.window);
      end else if (paddr == ADDR_STATUS) begin
         hit = 1'b1;
         rdata = 32'(r.status);
      end else if (paddr == ADDR_CLEAR) begin
         hit = 1'b1;
      end else if (paddr == ADDR_IRQ_EN) begin
         hit = 1'b1;
         rdata = 32'(r.irq_en);
      end else if (paddr == ADDR_DSIGN) begin
         hit = 1'b1;
         rdata = 32'(r.dsign); // R12
      end else if (paddr == ADDR_LSB) begin
         hit = 1'b1;
         rdata = LSB_PV_LOW; // R14
      end else if (in_blk(paddr, ADDR_RANGE, N_CH)) begin
         hit = 1'b1;
         i = blk_idx(paddr, ADDR_RANGE);
         rdata = 32'(r.range_sel[i]);
      end else if (in_blk(paddr, ADDR_ABS_THR, N_CH)) begin
         hit = 1'b1;
         i = blk_idx(paddr, ADDR_ABS_THR);
         rdata = 32'(r.abs_thr[i]);
      end else if (in_blk(paddr, ADDR_READING, N_CH)) begin
         hit = 1'b1;
         i = blk_idx(paddr, ADDR_READING);
         rdata = 32'($signed(rd[i])); // R5
      end else if (in_blk(paddr, ADDR_DIFF_THR, N_PAIR)) begin
         hit = 1'b1;
         i = blk_idx(paddr, ADDR_DIFF_THR);
         rdata = 32'(r.diff_thr[i]);
      end else if (in_blk(paddr, ADDR_DIFF_VAL, N_PAIR)) begin
         hit = 1'b1;
         i = blk_idx(paddr, ADDR_DIFF_VAL);
         rdata = 32'($signed(diff[i])); // R12
      end

      // Zero-wait APB: answer prepared during the setup cycle
      setup = psel && !penable;
      n.pready = setup;
      n.pslverr = setup && !hit;
      n.prdata = (setup && !pwrite && hit) ? rdata : '0;

      // Writes land at the access edge only
      wr = psel && penable && pwrite && r.pready && hit;
      if (wr) begin
         if (paddr == ADDR_CTRL) begin
            n.heater = pwdata[CTRL_HEATER_BIT];
         end else if (paddr == ADDR_WINDOW) begin
            // Out-of-span lengths are clamped, not refused
            if (pwdata > 32'(WIN_MAX)) begin // R4
               n.window = WIN_MAX;
            end else if (pwdata < 32'(WIN_MIN)) begin
               n.window = WIN_MIN;
            end else begin
               n.window = pwdata[9:0];
            end
         end else if (paddr == ADDR_CLEAR) begin
            clr = pwdata[9:0]; // R8
         end else if (paddr == ADDR_IRQ_EN) begin
            n.irq_en = pwdata[9:0];
         end else if (in_blk(paddr, ADDR_RANGE, N_CH)) begin
            i = blk_idx(paddr, ADDR_RANGE);
            // Codes past the last range are ignored
            if (pwdata[3:0] < N_RANGE) begin // R1
               n.range_sel[i] = pwdata[3:0];
            end
         end else if (in_blk(paddr, ADDR_ABS_THR, N_CH)) begin
            i = blk_idx(paddr, ADDR_ABS_THR);
            n.abs_thr[i] = pwdata[23:0]; // R10
         end else if (in_blk(paddr, ADDR_DIFF_THR, N_PAIR)) begin
            i = blk_idx(paddr, ADDR_DIFF_THR);
            n.diff_thr[i] = pwdata[24:0]; // R11
         end
      end

      // Compare once per filter update; all channels update together
      if (rd_valid[0]) begin
         for (int c = 0; c < N_CH; c++) begin
            set[c] = over_mag(25'($signed(rd[c])), {1'b0, r.abs_thr[c]}); // R6 R9
         end
         for (int k = 0; k < N_PAIR; k++) begin
            set[STAT_DIFF_LSB + k] = over_mag(diff[k], r.diff_thr[k]); // R11
            n.dsign[k] = diff[k][24]; // R12
         end
      end

      // Sticky flags; a new crossing beats a same-cycle clear
      n.status = (r.status & ~clr) | set; // R8
      n.quench = |n.status; // R7 R16
      n.irq = |(n.status & n.irq_en);
      // One control drives both heater outputs
      n.heat_a = n.heater; // R13
      n.heat_b = n.heater; // R13
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.window <= WINDOW_RST;
         r.range_sel <= {N_CH{RANGE_RST}};
         r.abs_thr <= {N_CH{ABS_THR_RST}};
         r.diff_thr <= {N_PAIR{DIFF_THR_RST}};
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign range_sel = r.range_sel;
   assign quench_relay = r.quench;
   assign switch_heater_output_a = r.heat_a;
   assign switch_heater_output_b = r.heat_b;
   assign irq = r.irq;
endmodule

// File: qtd_tap_source.sv
// Voltage-tap converter model feeding the four sample strobes
`timescale 1ns/10ps
module qtd_tap_source #(
   parameter int PERIOD = 20
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [3:0][23:0] level,
   output logic [3:0]            sample_valid,
   output logic [3:0][23:0]      sample_data
);
   int cnt;
   // All channels strobe together; data is garbage away from its strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         sample_valid <= 4'h0;
         sample_data <= '0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         sample_valid <= {4{cnt == 0}};
         sample_data <= (cnt == 0) ? level : ~sample_data;
      end
   end
endmodule

// File: qtd_top_assertions.sv
// Port-level checker for the quench threshold detector
`timescale 1ns/10ps
module qtd_top_checker import qtd_pkg::*; #(
   parameter int TICK_CYC = qtd_pkg::TICK_CYC
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic [7:0]       paddr,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic [3:0][3:0]  range_sel,
   input wire logic             quench_relay,
   input wire logic             switch_heater_output_a,
   input wire logic             switch_heater_output_b,
   input wire logic             irq
);
   logic wr_acc, clr_wr, ctrl_wr, setup, heat_wd;
   assign wr_acc  = psel && penable && pready && pwrite;
   assign clr_wr  = wr_acc && paddr == ADDR_CLEAR;
   assign ctrl_wr = wr_acc && paddr == ADDR_CTRL;
   assign setup   = psel && !penable;
   // Last heater bit written; outputs may lag it by a register stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         heat_wd <= 1'b0;
      else if (ctrl_wr)
         heat_wd <= pwdata[CTRL_HEATER_BIT];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_heater_pair: assert property (switch_heater_output_a == switch_heater_output_b)
      else $error("heater outputs differ");
   a_heater_follows: assert property (ctrl_wr |=> ##[0:1] switch_heater_output_a == heat_wd)
      else $error("heater output ignores control write");
   a_relay_latch: assert property (quench_relay && !clr_wr && !$past(clr_wr) |=> quench_relay)
      else $error("relay dropped without a clear");
   a_irq_needs_relay: assert property (irq |-> quench_relay)
      else $error("irq high while relay low");
   a_range_legal: assert property (range_sel[0] <= 4'ha && range_sel[1] <= 4'ha
      && range_sel[2] <= 4'ha && range_sel[3] <= 4'ha)
      else $error("range code out of span");
   a_lsb_value: assert property (setup && !pwrite && paddr == ADDR_LSB
      |=> prdata == LSB_PV_LOW)
      else $error("step size register wrong");
   a_window_span: assert property (setup && !pwrite && paddr == ADDR_WINDOW
      |=> prdata >= 32'(WIN_MIN) && prdata <= 32'(WIN_MAX))
      else $error("window outside span");
   a_ready_pulse: assert property (setup |=> pready ##1 !pready)
      else $error("ready not a single pulse");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
endmodule

bind qtd_top qtd_top_checker #(.TICK_CYC(TICK_CYC)) chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .range_sel(range_sel), .quench_relay(quench_relay), .irq(irq),
   .switch_heater_output_a(switch_heater_output_a),
   .switch_heater_output_b(switch_heater_output_b)
);

// File: quench_threshold_detector_test.sv
// Self-checking bench for the quench threshold detector
`timescale 1ns/10ps
module quench_threshold_detector_test;
   import qtd_pkg::*;
   localparam int TCK = 400;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic                relay, sw_a, sw_b, irq;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [3:0]          sample_valid;
   logic [3:0][23:0]    sample_data, level;
   logic [3:0][3:0]     range_sel;
   int                  bad_count, check_count;
   int                  lv[4] = '{100, 200, -300, 0};
   logic [31:0]         dexp[6] = '{300, 800, 500, 500, 200, 32'hffff_fed4};

   qtd_top #(.TICK_CYC(TCK)) uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
      .range_sel(range_sel), .quench_relay(relay), .irq(irq),
      .switch_heater_output_a(sw_a), .switch_heater_output_b(sw_b));
   qtd_tap_source src (.pclk(pclk), .presetn(presetn), .level(level),
      .sample_valid(sample_valid), .sample_data(sample_data));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (bad_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Only a missing answer is a timeout, not a late one at the bound
      if (pready !== 1'b1) begin
         bad_count++;
         finish_test();
      end
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      check(name, rd, exp);
      check({name, "_err"}, {31'h0, err}, 32'h0);
   endtask

   // Update periods are fixed by the tick parameter
   task automatic ticks(input int n);
      repeat (n * TCK) @(posedge pclk);
   endtask

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      finish_test();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, level} = '0;
      bad_count = 0;
      check_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, constants, unmapped access
      rdc("window", ADDR_WINDOW, 32'h1);
      rdc("abs_thr", ADDR_ABS_THR, 32'h00ff_ffff);
      rdc("lsb", ADDR_LSB, 32'h0000_09c4);
      apb(8'hfc, 1'b0, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      // Ranges per channel, illegal code refused
      for (int g = 0; g < 4; g++) begin
         apb(ADDR_RANGE + 8'(4 * g), 1'b1, 32'(g + 7));
      end
      apb(ADDR_RANGE, 1'b1, 32'hb);
      check("range_sel", 32'(range_sel), 32'h0000_a987);
      // Heater outputs switch together
      for (int h = 1; h >= 0; h--) begin
         apb(ADDR_CTRL, 1'b1, 32'(h));
         repeat (3) @(posedge pclk);
         check("heater", {30'h0, sw_a, sw_b}, {30'h0, {2{h[0]}}});
      end
      // Window clamping at both ends
      apb(ADDR_WINDOW, 1'b1, 32'h0);
      rdc("window_lo", ADDR_WINDOW, 32'h1);
      apb(ADDR_WINDOW, 1'b1, 32'd2000);
      rdc("window_hi", ADDR_WINDOW, 32'd1000);
      apb(ADDR_WINDOW, 1'b1, 32'h4);
      // Steady levels read back through the filters
      for (int g = 0; g < 4; g++) begin
         level[g] <= 24'(lv[g]);
      end
      ticks(6);
      for (int g = 0; g < 4; g++) begin
         rdc("reading", ADDR_READING + 8'(4 * g), 32'(lv[g]));
      end
      // Step on channel 1: window mixes old and new values first
      // Three periods: one full new block is in the window whatever the tick phase
      level[0] <= 24'd500;
      ticks(3);
      apb(ADDR_READING, 1'b0, 32'h0);
      check("window_mid", 32'(rd > 100 && rd < 500), 32'h1);
      ticks(6);
      rdc("window_end", ADDR_READING, 32'd500);
      for (int k = 0; k < 6; k++) begin
         rdc("diff_val", ADDR_DIFF_VAL + 8'(4 * k), dexp[k]);
      end
      rdc("dsign", ADDR_DSIGN, 32'h20);
      // Absolute thresholds: both polarities, equality does not trip
      apb(ADDR_ABS_THR, 1'b1, 32'd499);
      apb(ADDR_ABS_THR + 8'h4, 1'b1, 32'd200);
      apb(ADDR_ABS_THR + 8'h8, 1'b1, 32'd299);
      ticks(2);
      rdc("status", ADDR_STATUS, 32'h5);
      check("relay", {31'h0, relay}, 32'h1);
      check("irq_off", {31'h0, irq}, 32'h0);
      apb(ADDR_IRQ_EN, 1'b1, 32'h4);
      repeat (3) @(posedge pclk);
      check("irq_on", {31'h0, irq}, 32'h1);
      apb(ADDR_ABS_THR, 1'b1, 32'h00ff_ffff);
      apb(ADDR_ABS_THR + 8'h8, 1'b1, 32'h00ff_ffff);
      apb(ADDR_STATUS, 1'b1, 32'hffff_ffff);
      ticks(2);
      rdc("latched", ADDR_STATUS, 32'h5);
      apb(ADDR_CLEAR, 1'b1, 32'h5);
      repeat (3) @(posedge pclk);
      check("cleared", {30'h0, relay, irq}, 32'h0);
      // Pair thresholds: relay holds until the pair flag is cleared
      apb(ADDR_DIFF_THR, 1'b1, 32'd300);
      apb(ADDR_DIFF_THR + 8'h14, 1'b1, 32'd299);
      ticks(2);
      rdc("pair_stat", ADDR_STATUS, 32'h200);
      apb(ADDR_DIFF_THR + 8'h14, 1'b1, 32'h01ff_ffff);
      apb(ADDR_CLEAR, 1'b1, 32'h4);
      repeat (3) @(posedge pclk);
      check("relay_hold", {31'h0, relay}, 32'h1);
      apb(ADDR_CLEAR, 1'b1, 32'h200);
      repeat (3) @(posedge pclk);
      check("relay_drop", {31'h0, relay}, 32'h0);
      finish_test();
   end
endmodule
